/* dmsrs_pkg.sv */
// Package holding shared constants and types of the dual-mode serial ROM stream block.
package dmsrs_pkg;

  // ----------------------------------------
  // Array and stream layout
  // ----------------------------------------
  localparam int unsigned ARRAY_DEPTH    = 128;
  localparam int unsigned ADDR_W         = 7;
  localparam int unsigned BYTE_W         = 8;
  localparam logic [6:0]  ADDR_START     = 7'h00;
  localparam logic [6:0]  ADDR_LAST      = 7'h7F;
  localparam logic [3:0]  SLOT_NULL      = 4'h8;
  localparam logic [3:0]  SLOT_FIRST     = 4'h0;
  localparam logic [3:0]  SYNC_CYCLES    = 4'h9;
  // Bits reach the pin three link edges after leaving the FIFO, so sync must end that much early.
  localparam logic [3:0]  LINK_LEAD      = 4'h3;
  localparam logic [7:0]  FALLBACK_COUNT = 8'h80;
  localparam int unsigned FIFO_DEPTH     = 8;

  // ----------------------------------------
  // Control byte match
  // ----------------------------------------
  localparam logic [6:0]  DEV_CODE_RESET = 7'h2A;  // Arbitrary neutral value.

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {
    DMSRS_STREAM = 2'b00,
    DMSRS_TRANS  = 2'b01,
    DMSRS_BIDIR  = 2'b10
  } dmsrs_mode_t;

  typedef struct packed {
    logic       bit_val;
    logic       drive;
  } dmsrs_bit_t;

endpackage : dmsrs_pkg

/* dmsrs_fifo.sv */
// Small flip-flop FIFO with valid and ready on both sides.
`timescale 1ns/10ps
module dmsrs_fifo #(
  parameter int unsigned WIDTH = 2,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             ce_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  output logic      [WIDTH-1:0] out_data_o,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i
);
  localparam int unsigned PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr;
  logic [PW-1:0]    rd_ptr;
  logic [PW:0]      count;
  wire              push = in_valid_i && in_ready_o;
  wire              pop  = out_valid_o && out_ready_i;

  assign in_ready_o  = (count != (PW+1)'(DEPTH));
  assign out_valid_o = (count != '0);
  assign out_data_o  = mem[rd_ptr];

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end
    else if (ce_i)
    begin
      if (push)
      begin
        mem[wr_ptr] <= in_data_i;
        wr_ptr      <= (wr_ptr == PW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop)
        rd_ptr <= (rd_ptr == PW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      count <= count + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

  property p_no_overflow;
    @(posedge clk_i) disable iff (!rst_n_i)
    count <= (PW+1)'(DEPTH);
  endproperty
  a_no_overflow: assert property (p_no_overflow) else $error("FIFO count exceeds depth.");
endmodule : dmsrs_fifo

/* dmsrs_top.sv */
// Mode control and transmit-only streaming logic of the dual-mode serial ROM.
`timescale 1ns/10ps
module dmsrs_top #(
  parameter logic [6:0] DEV_CODE = dmsrs_pkg::DEV_CODE_RESET
) (
  input  wire logic       sys_clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       ce_i,
  input  wire logic       video_side_clock_i,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  input  wire logic       rom_we_i,
  input  wire logic [6:0] rom_waddr_i,
  input  wire logic [7:0] rom_wdata_i,
  output logic            sda_o,
  output logic            sda_oe_n_o,
  output logic [1:0]      mode_o,
  output logic            bidir_o
);
  // ----------------------------------------
  // Storage and system-side synchronisers
  // ----------------------------------------
  logic [7:0] rom [dmsrs_pkg::ARRAY_DEPTH];
  logic       scl_m;
  logic       scl_s;
  logic       scl_d;
  logic       sda_m;
  logic       sda_s;
  logic       sda_d;
  always_ff @(posedge sys_clk_i)
  begin
    if (ce_i && rom_we_i)
      rom[rom_waddr_i] <= rom_wdata_i;
  end
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      scl_d <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      sda_d <= 1'b1;
    end
    else if (ce_i)
    begin
      scl_m <= scl_i;
      scl_s <= scl_m;
      scl_d <= scl_s;
      sda_m <= sda_i;
      sda_s <= sda_m;
      sda_d <= sda_s;
    end
  end
  wire scl_fall = scl_d && !scl_s;
  wire scl_rise = !scl_d && scl_s;
  wire bus_start = scl_s && sda_d && !sda_s;
  // ----------------------------------------
  // Video-side pulse crossing
  // ----------------------------------------
  // Each video-side rising edge flips a toggle in the link domain so the
  // pulse count survives the unrelated clock phase.
  logic vtog;
  logic vtog_m;
  logic vtog_s;
  logic vtog_d;
  always_ff @(posedge video_side_clock_i)
  begin
    if (!rst_n_i)
      vtog <= 1'b0;
    else
      vtog <= ~vtog;
  end
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      vtog_m <= 1'b0;
      vtog_s <= 1'b0;
      vtog_d <= 1'b0;
    end
    else if (ce_i)
    begin
      vtog_m <= vtog;
      vtog_s <= vtog_m;
      vtog_d <= vtog_s;
    end
  end
  wire vpulse = vtog_s ^ vtog_d;
  // ----------------------------------------
  // Mode machine and control byte watch
  // ----------------------------------------
  dmsrs_pkg::dmsrs_mode_t mode;
  dmsrs_pkg::dmsrs_mode_t next_mode;
  logic [7:0] vcount;
  logic [7:0] shreg;
  logic [3:0] rx_bits;
  logic       restart;
  wire ctrl_hit = (rx_bits == 4'h8) && (shreg[7:1] == DEV_CODE);
  wire cnt_done = (vcount == dmsrs_pkg::FALLBACK_COUNT);
  always_comb
  begin
    next_mode = mode;
    case (mode)
      dmsrs_pkg::DMSRS_STREAM: if (scl_fall) next_mode = dmsrs_pkg::DMSRS_TRANS;
      dmsrs_pkg::DMSRS_TRANS:
        if (ctrl_hit) next_mode = dmsrs_pkg::DMSRS_BIDIR;
        else if (cnt_done && !scl_fall) next_mode = dmsrs_pkg::DMSRS_STREAM;
      dmsrs_pkg::DMSRS_BIDIR: next_mode = dmsrs_pkg::DMSRS_BIDIR;
      default: next_mode = dmsrs_pkg::DMSRS_STREAM;
    endcase
  end
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      mode    <= dmsrs_pkg::DMSRS_STREAM;
      vcount  <= 8'h00;
      shreg   <= 8'h00;
      rx_bits <= 4'h0;
      restart <= 1'b0;
    end
    else if (ce_i)
    begin
      mode    <= next_mode;
      restart <= (mode == dmsrs_pkg::DMSRS_TRANS) && (next_mode == dmsrs_pkg::DMSRS_STREAM);
      if (mode != dmsrs_pkg::DMSRS_TRANS || scl_fall)
        vcount <= 8'h00;
      else if (vpulse && !cnt_done)
        vcount <= vcount + 8'h01;
      if (mode != dmsrs_pkg::DMSRS_TRANS || bus_start)
        rx_bits <= 4'h0;
      else if (scl_rise)
      begin
        shreg   <= {shreg[6:0], sda_s};
        rx_bits <= (rx_bits == 4'h8) ? 4'h1 : rx_bits + 4'h1;
      end
    end
  end
  // ----------------------------------------
  // Bit producer on the system clock
  // ----------------------------------------
  logic [6:0] addr;
  logic [3:0] slot;
  logic [3:0] sync_cnt;
  logic       synced;
  wire produce = (mode == dmsrs_pkg::DMSRS_STREAM) && synced && !restart;
  wire [7:0] cur_byte = rom[addr];
  dmsrs_pkg::dmsrs_bit_t pbit;
  assign pbit.bit_val = (slot == dmsrs_pkg::SLOT_NULL) ? 1'b1 : cur_byte[3'(4'h7 - slot)];
  assign pbit.drive   = (slot != dmsrs_pkg::SLOT_NULL);
  logic fifo_in_ready;
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      addr     <= dmsrs_pkg::ADDR_START;
      slot     <= dmsrs_pkg::SLOT_FIRST;
      sync_cnt <= 4'h0;
      synced   <= 1'b0;
    end
    else if (ce_i)
    begin
      if (!synced && vpulse)
      begin
        sync_cnt <= sync_cnt + 4'h1;
        if (sync_cnt == dmsrs_pkg::SYNC_CYCLES - dmsrs_pkg::LINK_LEAD - 4'h1)
          synced <= 1'b1;
      end
      if (restart || mode != dmsrs_pkg::DMSRS_STREAM)
      begin
        addr <= dmsrs_pkg::ADDR_START;
        slot <= dmsrs_pkg::SLOT_FIRST;
      end
      else if (produce && fifo_in_ready)
      begin
        slot <= (slot == dmsrs_pkg::SLOT_NULL) ? dmsrs_pkg::SLOT_FIRST : slot + 4'h1;
        if (slot == dmsrs_pkg::SLOT_NULL)
          addr <= (addr == dmsrs_pkg::ADDR_LAST) ? dmsrs_pkg::ADDR_START : addr + 7'h01;
      end
    end
  end
  // ----------------------------------------
  // Bit FIFO and link-side handoff
  // ----------------------------------------
  // The FIFO drains one bit per video-side pulse, so the producer stalls
  // once eight bits are queued ahead of the link.
  dmsrs_pkg::dmsrs_bit_t fifo_out;
  logic fifo_out_valid;
  logic fifo_pop;
  dmsrs_fifo #(
    .WIDTH ($bits(dmsrs_pkg::dmsrs_bit_t)),
    .DEPTH (dmsrs_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (sys_clk_i),
    .rst_n_i     (rst_n_i && !restart && mode == dmsrs_pkg::DMSRS_STREAM),
    .ce_i        (ce_i),
    .in_data_i   (pbit),
    .in_valid_i  (produce),
    .in_ready_o  (fifo_in_ready),
    .out_data_o  (fifo_out),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (fifo_pop)
  );
  // pop one bit per video-side pulse
  assign fifo_pop = vpulse && synced && (mode == dmsrs_pkg::DMSRS_STREAM);
  // Held bit on the system side, stable between pops so the link side
  // samples it safely through its own two-stage synchroniser.
  dmsrs_pkg::dmsrs_bit_t held;
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
      held <= '{bit_val: 1'b1, drive: 1'b0};
    else if (ce_i)
    begin
      if (mode != dmsrs_pkg::DMSRS_STREAM)
        held <= '{bit_val: 1'b1, drive: 1'b0};
      else if (fifo_pop)
        held <= fifo_out_valid ? fifo_out : '{bit_val: 1'b1, drive: 1'b0};
    end
  end
  // ----------------------------------------
  // Outputs: data line on the link clock, mode outputs on the system clock
  // ----------------------------------------
  dmsrs_pkg::dmsrs_bit_t held_m;
  dmsrs_pkg::dmsrs_bit_t held_s;
  // data line driven on video-side rising edge
  always_ff @(posedge video_side_clock_i)
  begin
    if (!rst_n_i)
    begin
      held_m     <= '{bit_val: 1'b1, drive: 1'b0};
      held_s     <= '{bit_val: 1'b1, drive: 1'b0};
      sda_o      <= 1'b1;
      sda_oe_n_o <= 1'b1;
    end
    else
    begin
      held_m     <= held;
      held_s     <= held_m;
      sda_o      <= held_s.bit_val;
      sda_oe_n_o <= !held_s.drive;
    end
  end
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      mode_o  <= 2'b00;
      bidir_o <= 1'b0;
    end
    else if (ce_i)
    begin
      mode_o  <= next_mode;
      bidir_o <= (next_mode == dmsrs_pkg::DMSRS_BIDIR);
    end
  end
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  property p_bidir_sticky;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    mode == dmsrs_pkg::DMSRS_BIDIR |=> mode == dmsrs_pkg::DMSRS_BIDIR;
  endproperty
  a_bidir_sticky: assert property (p_bidir_sticky) else $error("Left bidirectional mode.");
  property p_fall_enters;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    (ce_i && mode == dmsrs_pkg::DMSRS_STREAM && scl_fall) |=> mode == dmsrs_pkg::DMSRS_TRANS;
  endproperty
  a_fall_enters: assert property (p_fall_enters) else $error("Clock fall did not enter transition.");
  property p_hit_commits;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    (ce_i && mode == dmsrs_pkg::DMSRS_TRANS && ctrl_hit) |=> mode == dmsrs_pkg::DMSRS_BIDIR;
  endproperty
  a_hit_commits: assert property (p_hit_commits) else $error("Control byte not committed.");
  property p_fallback;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    (ce_i && mode == dmsrs_pkg::DMSRS_TRANS && cnt_done && !ctrl_hit && !scl_fall)
      |=> mode == dmsrs_pkg::DMSRS_STREAM ##1 (addr == dmsrs_pkg::ADDR_START);
  endproperty
  a_fallback: assert property (p_fallback) else $error("Fall-back not to address zero.");
  property p_clear_cnt;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    (ce_i && scl_fall) |=> vcount == 8'h00;
  endproperty
  a_clear_cnt: assert property (p_clear_cnt) else $error("Counter not cleared on clock fall.");
  property p_cnt_sat;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    vcount <= dmsrs_pkg::FALLBACK_COUNT;
  endproperty
  a_cnt_sat: assert property (p_cnt_sat) else $error("Counter passed saturation.");
  property p_sync_quiet;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    !synced |-> !held.drive;
  endproperty
  a_sync_quiet: assert property (p_sync_quiet) else $error("Data driven before sync.");
  property p_wrap;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    (ce_i && produce && fifo_in_ready && slot == dmsrs_pkg::SLOT_NULL && addr == dmsrs_pkg::ADDR_LAST
      && mode == dmsrs_pkg::DMSRS_STREAM && !restart) |=> addr == dmsrs_pkg::ADDR_START;
  endproperty
  a_wrap: assert property (p_wrap) else $error("Address did not wrap.");
  c_trans: cover property (@(posedge sys_clk_i) mode == dmsrs_pkg::DMSRS_TRANS);
  c_bidir: cover property (@(posedge sys_clk_i) mode == dmsrs_pkg::DMSRS_BIDIR);
  c_back:  cover property (@(posedge sys_clk_i) restart);
endmodule : dmsrs_top

/* dmsrs_host.sv */
// Host model driving the link clock and the bidirectional-mode bus.
`timescale 1ns/10ps
module dmsrs_host (
  input  wire logic sys_clk_i,
  output logic      video_side_clock_o,
  output logic      scl_o,
  output logic      sda_low_o
);
  int phase = 3;
  // ----------------------------------------
  // Idle levels
  // ----------------------------------------
  // link clock held low, scl held high
  initial
  begin
    video_side_clock_o = 1'b0;
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  // ----------------------------------------
  // Bus actions
  // ----------------------------------------
  // A 15 ns pulse at a shifting phase; the clock stands still between pulses.
  // The gap keeps pulses slower than the crossing can count.
  task automatic pulse();
    @(negedge sys_clk_i);
    #(phase);
    video_side_clock_o = 1'b1;
    #15;
    video_side_clock_o = 1'b0;
    phase = (phase + 13) % 80 + 1;
    repeat (5) @(negedge sys_clk_i);
  endtask : pulse
  task automatic step();
    repeat (4) @(negedge sys_clk_i);
  endtask : step
  task automatic scl_fall();
    scl_o = 1'b0;
    step();
    scl_o = 1'b1;
    step();
  endtask : scl_fall
  // Start, eight bits with an acknowledge slot, then stop; open drain only.
  task automatic send_byte(input logic [7:0] v);
    sda_low_o = 1'b1;
    step();
    scl_o = 1'b0;
    step();
    for (int i = 8; i >= 0; i--)
    begin
      sda_low_o = (i > 0) ? ~v[i-1] : 1'b0;
      step();
      scl_o = 1'b1;
      step();
      scl_o = 1'b0;
      step();
    end
    sda_low_o = 1'b1;
    step();
    scl_o = 1'b1;
    step();
    sda_low_o = 1'b0;
    step();
  endtask : send_byte
endmodule : dmsrs_host

/* dual_mode_serial_rom_stream_bench.sv */
// Self-checking bench of the dual-mode serial ROM stream block.
`timescale 1ns/10ps
module dual_mode_serial_rom_stream_bench;
  logic       sys_clk_i;
  logic       rst_n_i;
  logic       ce_i;
  logic       rom_we_i;
  logic [6:0] rom_waddr_i;
  logic [7:0] rom_wdata_i;
  wire        video_clk;
  wire        scl;
  wire        host_low;
  wire        sda_line;
  logic       sda_o;
  logic       sda_oe_n_o;
  logic [1:0] mode_o;
  logic       bidir_o;
  logic [7:0] rom_img [128];
  int         seed = 50018;
  int         num_errors = 0;
  int         comparisons = 0;
  int         cycles = 0;
  // ----------------------------------------
  // Wiring
  // ----------------------------------------
  // The data line has a pull-up; either party may pull it low.
  assign sda_line = (sda_oe_n_o === 1'b0 ? sda_o : 1'b1) & ~host_low;
  dmsrs_top dut_u (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
    .video_side_clock_i(video_clk), .scl_i(scl), .sda_i(sda_line),
    .rom_we_i(rom_we_i), .rom_waddr_i(rom_waddr_i), .rom_wdata_i(rom_wdata_i),
    .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o), .mode_o(mode_o), .bidir_o(bidir_o)
  );
  dmsrs_host host_u (
    .sys_clk_i(sys_clk_i), .video_side_clock_o(video_clk), .scl_o(scl), .sda_low_o(host_low)
  );
  initial
  begin
    sys_clk_i = 1'b0;
    forever #50 sys_clk_i = ~sys_clk_i;
  end
  always @(posedge sys_clk_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 30000)
    begin
      num_errors++;
      stop_test();
    end
  end
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Expected {release, bit} of stream slot k; a null slot only releases.
  function automatic logic [1:0] exp_slot(input int k);
    int s;
    s = k % 9;
    if (s == 8)
      return 2'b10;
    return {1'b0, rom_img[(k / 9) % 128][7 - s]};
  endfunction : exp_slot
  task automatic stream_chk(input int nbits, input int min_idle, input int max_idle);
    int n;
    n = 0;
    do
    begin
      host_u.pulse();
      n++;
    end while (sda_oe_n_o !== 1'b0 && n < 60);
    chk(8'(n >= min_idle && n <= max_idle), 8'h01);
    for (int k = 0; k < nbits; k++)
    begin
      if (k > 0)
        host_u.pulse();
      chk(8'({sda_oe_n_o, sda_oe_n_o === 1'b1 ? 1'b0 : sda_o}), 8'(exp_slot(k)));
    end
  endtask : stream_chk
  task automatic reset_dut();
    @(negedge sys_clk_i);
    rst_n_i = 1'b0;
    repeat (2) host_u.pulse();
    repeat (3) @(negedge sys_clk_i);
    chk(8'({sda_oe_n_o, mode_o}), 8'h04);
    @(negedge sys_clk_i);
    rst_n_i = 1'b1;
    for (int a = 0; a < 128; a++)
    begin
      @(negedge sys_clk_i);
      rom_we_i = 1'b1;
      rom_waddr_i = 7'(a);
      rom_wdata_i = rom_img[a];
    end
    @(negedge sys_clk_i);
    rom_we_i = 1'b0;
    chk(8'(mode_o), 8'(dmsrs_pkg::DMSRS_STREAM));
  endtask : reset_dut
  task automatic bidir_run(input logic rw);
    int n;
    n = 0;
    while (sda_oe_n_o !== 1'b1 && n < 10)
    begin
      host_u.pulse();
      n++;
    end
    host_u.send_byte({dmsrs_pkg::DEV_CODE_RESET ^ 7'h01, rw});
    chk(8'({bidir_o, mode_o}), 8'(dmsrs_pkg::DMSRS_TRANS));
    host_u.send_byte({dmsrs_pkg::DEV_CODE_RESET, rw});
    chk(8'({bidir_o, mode_o}), 8'h06);
    repeat (200) host_u.pulse();
    chk(8'({bidir_o, mode_o}), 8'h06);
    $display("Test commit rw=%0b done", rw);
  endtask : bidir_run
  task automatic stop_test();
    $display("Comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : stop_test
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    rst_n_i = 1'b0;
    ce_i = 1'b1;
    rom_we_i = 1'b0;
    rom_waddr_i = 7'h00;
    rom_wdata_i = 8'h00;
    for (int a = 0; a < 128; a++)
      rom_img[a] = 8'($random(seed));
    rom_img[0] = 8'h80;
    rom_img[127] = 8'h01;
    reset_dut();
    stream_chk(9 * 130, int'(dmsrs_pkg::SYNC_CYCLES) + 1, int'(dmsrs_pkg::SYNC_CYCLES) + 1);
    $display("Test stream done");
    host_u.scl_fall();
    chk(8'(mode_o), 8'(dmsrs_pkg::DMSRS_TRANS));
    repeat (100) host_u.pulse();
    chk(8'(sda_oe_n_o), 8'h01);
    host_u.scl_fall();
    repeat (127) host_u.pulse();
    chk(8'(mode_o), 8'(dmsrs_pkg::DMSRS_TRANS));
    host_u.pulse();
    repeat (10) @(negedge sys_clk_i);
    chk(8'(mode_o), 8'(dmsrs_pkg::DMSRS_STREAM));
    stream_chk(9 * 3, 1, 60);
    $display("Test fall-back done");
    bidir_run(1'b0);
    reset_dut();
    ce_i = 1'b0;
    host_u.scl_fall();
    ce_i = 1'b1;
    chk(8'(mode_o), 8'(dmsrs_pkg::DMSRS_STREAM));
    $display("Test enable freeze done");
    bidir_run(1'b1);
    stop_test();
  end
endmodule : dual_mode_serial_rom_stream_bench
